/* sim/bsrd_bank6_assertions.sv */
`timescale 1ns/100ps
module bsrd_bank6_assertions #(
    parameter bit REDUCED = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rst_por,
    input wire logic rst_wdt,
    input wire logic rst_sleep,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [13:0] wb_adr,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    input wire logic wb_err,
    input wire bsrd_pkg::bsrd_mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdat,
    input wire logic pc_jump,
    input wire logic [10:0] pc_target,
    input wire logic [14:0] pc,
    input wire bsrd_pkg::bsrd_sfr_t sfr
);
    // ****************************************
    // Decode of the request seen on the bus
    // ****************************************
    logic [6:0] ofs;
    logic core, foreign, unimpl;
    logic [15:0] ptr;
    assign ofs = wb_adr[8:2];
    assign core = ofs < 7'h0c;
    assign foreign = wb_adr[13:9] != bsrd_pkg::BANK_OWN;
    // Only the decoded tail of the bank, the rest is not ours to judge
    assign unimpl = !foreign && (ofs inside {[7'h0c:7'h10], 7'h17, 7'h1b, 7'h1f}
        || (REDUCED && ofs inside {[7'h1c:7'h1e]}));
    assign ptr = ofs[0] ? sfr.ptr_b : sfr.ptr_a;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence req_s;
        wb_cyc && wb_stb && !$past(wb_stb);
    endsequence
    sequence ext_done_s;
        mem_req.stb && mem_ack && !mem_req.we;
    endsequence
    property unimpl_wr_p;
        req_s ##0 (unimpl && wb_we) |=> wb_ack ##1 sfr == $past(sfr);
    endproperty

    // ****************************************
    // Checks
    // ****************************************
    core_any_bank_a: assert property (req_s ##0 (core && ofs > 7'h01) |=> wb_ack && !wb_err)
        else $error("core offset not answered in one cycle");
    foreign_err_a: assert property (req_s ##0 (foreign && !core) |=> wb_err && !wb_ack)
        else $error("foreign bank not refused");
    unimpl_zero_a: assert property (req_s ##0 (unimpl && !wb_we) |=> wb_ack && wb_dat_r == 32'h0)
        else $error("unimplemented location not zero");
    upper_zero_a: assert property (wb_ack |-> wb_dat_r[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    unimpl_write_a: assert property (unimpl_wr_p)
        else $error("write to unimplemented location changed a register");
    ind_ext_req_a: assert property (req_s ##0 (ofs < 7'h02 && ptr[15:12] != 4'h0)
        |=> mem_req.stb && mem_req.adr == $past(ptr))
        else $error("indirect request not sent to pointer address");
    ind_ext_done_a: assert property (ext_done_s |=> wb_ack && !mem_req.stb
        && wb_dat_r[7:0] == $past(mem_rdat))
        else $error("indirect read data not returned");
    pc_jump_a: assert property (pc_jump |=> pc == {$past(sfr.pc_latch[6:3]), $past(pc_target)})
        else $error("jump did not take latch bits");
    por_status_a: assert property ($past(rst) && $past(rst_por) |-> sfr.status == 8'h18)
        else $error("power-on status value wrong");
    warm_status_a: assert property ($past(rst) && !$past(rst_por)
        |-> sfr.status[4:3] == {!$past(rst_wdt), !$past(rst_sleep)})
        else $error("reset cause flags wrong");
endmodule // bsrd_bank6_assertions

bind bsrd_bank6 bsrd_bank6_assertions #(.REDUCED(REDUCED)) u_bsrd_bank6_assertions (
    .clk_sys(clk_sys), .rst(rst), .rst_por(rst_por), .rst_wdt(rst_wdt), .rst_sleep(rst_sleep),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .wb_err(wb_err), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdat(mem_rdat), .pc_jump(pc_jump), .pc_target(pc_target), .pc(pc), .sfr(sfr));

/* sim/bsrd_bank6_tb.sv */
`timescale 1ns/100ps
module bsrd_bank6_tb;
    // ****************************************
    // Design and stimulus state
    // ****************************************
    logic clk_sys, rst, rst_por, rst_wdt, rst_sleep, wb_cyc, wb_stb, wb_we, wb_ack, wb_err;
    logic mem_ack, pc_step, pc_jump;
    logic [13:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, r, r2;
    logic [7:0] mem_rdat, d;
    logic [10:0] pc_target;
    logic [14:0] pc;
    logic [11:0] i;
    logic [4:0] b;
    bsrd_pkg::bsrd_mem_req_t mem_req;
    bsrd_pkg::bsrd_sfr_t sfr;
    typedef struct packed {logic err; logic chk; logic [7:0] dat;} bsrd_note_t;
    bsrd_note_t notes[$];
    bsrd_note_t nt;
    int mismatches, total_checks, cycles, n;
    logic [15:0] mem_adr_exp;
    integer seed;

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    bsrd_bank6 #(.REDUCED(1'b1)) u_bsrd_bank6 (
        .clk_sys(clk_sys), .rst(rst), .rst_por(rst_por), .rst_wdt(rst_wdt),
        .rst_sleep(rst_sleep), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .wb_err(wb_err), .mem_req(mem_req), .mem_ack(mem_ack),
        .mem_rdat(mem_rdat), .pc_step(pc_step), .pc_jump(pc_jump), .pc_target(pc_target),
        .pc(pc), .sfr(sfr));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Kind: 0 ack, 1 ack with data, 2 error, 3 external (memory side notes it)
    task automatic bus(input logic we, input logic [11:0] idx, input logic [7:0] dat,
        input logic [1:0] kind, input logic [7:0] exp);
        if (kind != 2'd3) notes.push_back({kind == 2'd2, kind == 2'd1, exp});
        @(posedge clk_sys);
        r = $random(seed);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, r[1:0]};
        wb_dat_w <= {r[31:8], dat};
        // Only the bench timeout ends a wait that never gets an answer
        do begin
            @(posedge clk_sys);
        end while (!(wb_ack || wb_err));
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic do_reset(input logic por, input logic wdt, input logic slp);
        rst <= 1'b1;
        rst_por <= por;
        rst_wdt <= wdt;
        rst_sleep <= slp;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
    endtask

    function automatic logic [7:0] wmask(input logic [11:0] x);
        case (x)
            12'h303: return 8'h07;
            12'h308, 12'h316: return 8'h1f;
            12'h30a: return 8'h7f;
            12'h31a: return 8'h3f;
            12'h302, 12'h304, 12'h305, 12'h306, 12'h307, 12'h309, 12'h30b, 12'h311, 12'h312,
                12'h313, 12'h314, 12'h315, 12'h318, 12'h319: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction

    // ****************************************
    // Answer checker and memory side
    // ****************************************
    always @(posedge clk_sys) begin
        if (!rst && (wb_ack || wb_err)) begin
            if (notes.size() == 0) cmp("unexpected answer", 16'h0, 16'h1);
            else begin
                nt = notes.pop_front();
                cmp("error flag", {15'h0, nt.err}, {15'h0, wb_err});
                if (nt.chk) cmp("read data", {8'h0, nt.dat}, wb_dat_r[15:0]);
            end
        end
    end

    // Data lines toggle while idle so a stale value is never mistaken for an answer
    always @(posedge clk_sys) begin
        r2 = $random(seed);
        mem_ack <= 1'b0;
        mem_rdat <= ~mem_rdat;
        if (mem_req.stb === 1'b1 && !mem_ack && r2[9]) begin
            mem_ack <= 1'b1;
            mem_rdat <= r2[7:0];
            notes.push_back({1'b0, !mem_req.we, r2[7:0]});
            cmp("memory address", mem_adr_exp, mem_req.adr);
            if (mem_req.we) cmp("memory data", {8'h0, d}, {8'h0, mem_req.wdat});
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 32'h4523;
        {rst_wdt, rst_sleep, wb_cyc, wb_stb, wb_we, mem_ack, pc_step, pc_jump} = 8'h00;
        {rst, rst_por} = 2'b11;
        {wb_adr, wb_dat_w, pc_target, cycles, mismatches, total_checks} = '0;
        wb_sel = 4'h1;
        mem_rdat = 8'h5a;
        mem_adr_exp = 16'h1234;
        do_reset(1'b1, 1'b0, 1'b0);
        for (i = 12'h302; i <= 12'h31f; i++) begin
            bus(1'b0, i, 8'h00, 2'd1, i == 12'h303 ? 8'h18 : i == 12'h316 ? 8'h01 : 8'h00);
        end
        for (i = 12'h302; i <= 12'h31f; i++) begin
            d = $random(seed);
            b = $random(seed);
            bus(1'b1, i, d, 2'd0, 8'h00);
            bus(1'b0, i < 12'h30c ? {b, i[6:0]} : i, 8'h00, 2'd1,
                (d & wmask(i)) | (i == 12'h303 ? 8'h18 : 8'h00));
        end
        bus(1'b1, 12'h291, 8'h77, 2'd2, 8'h00);
        bus(1'b1, 12'h309, 8'h96, 2'd0, 8'h00);
        wb_sel <= 4'he;
        bus(1'b1, 12'h309, 8'h3c, 2'd0, 8'h00);
        wb_sel <= 4'h1;
        bus(1'b0, 12'h309, 8'h00, 2'd1, 8'h96);
        bus(1'b1, 12'h305, 8'h12, 2'd0, 8'h00);
        bus(1'b1, 12'h304, 8'h34, 2'd0, 8'h00);
        bus(1'b1, 12'h307, 8'h03, 2'd0, 8'h00);
        bus(1'b1, 12'h306, 8'h09, 2'd0, 8'h00);
        for (n = 0; n < 4; n++) begin
            d = $random(seed);
            bus(n[0], {n[1] ? 5'h02 : 5'h06, 7'h00}, d, 2'd3, 8'h00);
            bus(1'b1, 12'h301, d, 2'd0, 8'h00);
            bus(1'b0, 12'h309, 8'h00, 2'd1, d);
            bus(1'b0, 12'h301, 8'h00, 2'd1, d);
        end
        // Port b aimed at port a finds no storage
        bus(1'b1, 12'h306, 8'h00, 2'd0, 8'h00);
        bus(1'b1, 12'h301, 8'h6b, 2'd0, 8'h00);
        bus(1'b0, 12'h301, 8'h00, 2'd1, 8'h00);
        bus(1'b1, 12'h30a, 8'hd5, 2'd0, 8'h00);
        r = $random(seed);
        pc_target <= r[10:0];
        pc_jump <= 1'b1;
        @(posedge clk_sys);
        pc_jump <= 1'b0;
        pc_step <= 1'b1;
        @(posedge clk_sys);
        pc_step <= 1'b0;
        cmp("pc after jump", {1'b0, 4'ha, r[10:0]}, {1'b0, pc});
        @(posedge clk_sys);
        cmp("pc after step", {1'b0, 4'ha, r[10:0]} + 16'h1, {1'b0, pc});
        bus(1'b1, 12'h302, 8'h3c, 2'd0, 8'h00);
        @(posedge clk_sys);
        cmp("pc after low write", {1'b0, 7'h55, 8'h3c}, {1'b0, pc});
        for (n = 0; n < 2; n++) begin
            bus(1'b1, 12'h303, 8'h05, 2'd0, 8'h00);
            bus(1'b1, 12'h309, 8'ha5, 2'd0, 8'h00);
            do_reset(1'b0, n[0], !n[0]);
            bus(1'b0, 12'h303, 8'h00, 2'd1, n[0] ? 8'h0d : 8'h15);
            bus(1'b0, 12'h309, 8'h00, 2'd1, 8'ha5);
            bus(1'b0, 12'h30a, 8'h00, 2'd1, 8'h00);
        end
        tally_and_finish();
    end
endmodule // bsrd_bank6_tb

/* src/bsrd_bank6.sv */
`timescale 1ns/100ps
module bsrd_bank6 #(
    parameter bit REDUCED = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rst_por,
    input wire logic rst_wdt,
    input wire logic rst_sleep,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [13:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic wb_err,
    output bsrd_pkg::bsrd_mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdat,
    input wire logic pc_step,
    input wire logic pc_jump,
    input wire logic [10:0] pc_target,
    output logic [14:0] pc,
    output bsrd_pkg::bsrd_sfr_t sfr
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic is_core(input logic [11:0] idx);
        is_core = idx[6:0] < bsrd_pkg::CORE_END;
    endfunction

    function automatic logic is_local(input logic [11:0] idx);
        is_local = is_core(idx) || idx[11:7] == bsrd_pkg::BANK_OWN;
    endfunction

    function automatic logic is_ind(input logic [11:0] idx);
        is_ind = is_core(idx) && idx[6:1] == 6'h00;
    endfunction

    // Core offsets fold onto the own bank so one case serves every bank
    function automatic logic [11:0] fold(input logic [11:0] idx);
        fold = is_core(idx) ? {bsrd_pkg::BANK_OWN, idx[6:0]} : idx;
    endfunction

    function automatic logic absent(input logic [11:0] key);
        absent = REDUCED && key >= bsrd_pkg::IDX_CC5_VLO
            && key <= bsrd_pkg::IDX_CC5_CTL;
    endfunction

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] status_q;
    logic [7:0] ptr_a_lo_q;
    logic [7:0] ptr_a_hi_q;
    logic [7:0] ptr_b_lo_q;
    logic [7:0] ptr_b_hi_q;
    logic [4:0] bank_q;
    logic [7:0] wacc_q;
    logic [6:0] pc_latch_q;
    logic [7:0] int_ctl_q;
    logic [7:0] cc_val_q [bsrd_pkg::CC_VALS];
    logic [7:0] cc3_ctl_q;
    logic [7:0] cc3_db_q;
    logic [7:0] cc3_as_q;
    logic [4:0] cc3_str_q;
    logic [5:0] cc4_ctl_q;
    logic [5:0] cc5_ctl_q;
    logic [7:0] rd_q;
    logic ack_q;
    logic err_q;
    bsrd_pkg::bsrd_state_t state_q;
    bsrd_pkg::bsrd_mem_req_t mreq_q;

    // ****************************************
    // Request decode
    // ****************************************
    logic req;
    logic [11:0] dir_idx;
    logic dir_ind;
    logic [15:0] ptr;
    logic ptr_local;
    logic go_ext;
    logic nested;
    logic mapped;
    logic [11:0] key;
    logic wr;
    logic [7:0] wdat;
    logic [7:0] rd_val;
    logic idle_req;

    assign req = wb_cyc && wb_stb;
    assign dir_idx = wb_adr[13:2];
    assign dir_ind = is_ind(dir_idx);
    assign ptr = dir_idx[0] ? {ptr_b_hi_q, ptr_b_lo_q} : {ptr_a_hi_q, ptr_a_lo_q};
    assign ptr_local = ptr[15:12] == 4'h0 && is_local(ptr[11:0]);
    assign go_ext = dir_ind && !ptr_local;
    // An indirect port aimed at an indirect port finds no storage
    assign nested = dir_ind && ptr_local && is_ind(ptr[11:0]);
    assign mapped = is_local(dir_idx);
    assign key = fold(dir_ind ? ptr[11:0] : dir_idx);
    assign wdat = wb_dat_w[7:0];
    assign idle_req = req && state_q == bsrd_pkg::ST_IDLE && !ack_q && !err_q;
    // Writes land on the edge where the master sees ack
    assign wr = req && wb_we && wb_sel[0] && ack_q && mapped && !go_ext && !nested
        && !absent(key);

    function automatic logic hit(input logic [11:0] idx);
        hit = wr && key == idx;
    endfunction

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rd_val = bsrd_pkg::RST_ZERO;
        case (key)
            bsrd_pkg::IDX_PC_LOW: rd_val = pc[7:0];
            bsrd_pkg::IDX_STATUS: rd_val = status_q;
            bsrd_pkg::IDX_PTR_A_LO: rd_val = ptr_a_lo_q;
            bsrd_pkg::IDX_PTR_A_HI: rd_val = ptr_a_hi_q;
            bsrd_pkg::IDX_PTR_B_LO: rd_val = ptr_b_lo_q;
            bsrd_pkg::IDX_PTR_B_HI: rd_val = ptr_b_hi_q;
            bsrd_pkg::IDX_BANK_SEL: rd_val = {3'h0, bank_q};
            bsrd_pkg::IDX_WACC: rd_val = wacc_q;
            bsrd_pkg::IDX_PC_LATCH: rd_val = {1'b0, pc_latch_q};
            bsrd_pkg::IDX_INT_CTL: rd_val = int_ctl_q;
            bsrd_pkg::IDX_CC3_VLO: rd_val = cc_val_q[0];
            bsrd_pkg::IDX_CC3_VHI: rd_val = cc_val_q[1];
            bsrd_pkg::IDX_CC3_CTL: rd_val = cc3_ctl_q;
            bsrd_pkg::IDX_CC3_DB: rd_val = cc3_db_q;
            bsrd_pkg::IDX_CC3_AS: rd_val = cc3_as_q;
            bsrd_pkg::IDX_CC3_STR: rd_val = {3'h0, cc3_str_q};
            bsrd_pkg::IDX_CC4_VLO: rd_val = cc_val_q[2];
            bsrd_pkg::IDX_CC4_VHI: rd_val = cc_val_q[3];
            bsrd_pkg::IDX_CC4_CTL: rd_val = {2'h0, cc4_ctl_q};
            bsrd_pkg::IDX_CC5_VLO: rd_val = cc_val_q[4];
            bsrd_pkg::IDX_CC5_VHI: rd_val = cc_val_q[5];
            bsrd_pkg::IDX_CC5_CTL: rd_val = {2'h0, cc5_ctl_q};
            default: rd_val = bsrd_pkg::RST_ZERO;
        endcase
        rd_val = rd_val | bsrd_pkg::ONES_NONE;
        if (absent(key) || nested || !mapped) begin
            rd_val = bsrd_pkg::RST_ZERO;
        end
    end

    // ****************************************
    // Bus handshake
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= bsrd_pkg::ST_IDLE;
            mreq_q <= '0;
        end else begin
            case (state_q)
                bsrd_pkg::ST_IDLE: begin
                    if (idle_req && mapped && go_ext) begin
                        mreq_q.stb <= 1'b1;
                        mreq_q.we <= wb_we && wb_sel[0];
                        mreq_q.adr <= ptr;
                        mreq_q.wdat <= wdat;
                        state_q <= bsrd_pkg::ST_EXT;
                    end
                end
                bsrd_pkg::ST_EXT: begin
                    if (mem_ack) begin
                        mreq_q.stb <= 1'b0;
                        state_q <= bsrd_pkg::ST_DONE;
                    end
                end
                bsrd_pkg::ST_DONE: state_q <= bsrd_pkg::ST_IDLE;
                default: state_q <= bsrd_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= idle_req && mapped && !go_ext;
            // Non-core offsets of other banks belong to other decoders; answer them with err
            err_q <= idle_req && !mapped;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_q <= bsrd_pkg::RST_ZERO;
        end else if (state_q == bsrd_pkg::ST_EXT && mem_ack) begin
            rd_q <= mem_rdat;
        end else if (idle_req) begin
            rd_q <= rd_val;
        end
    end

    assign wb_ack = ack_q || state_q == bsrd_pkg::ST_DONE;
    assign wb_err = err_q;
    assign wb_dat_r = {24'h000000, rd_q};
    assign mem_req = mreq_q;

    // ****************************************
    // Core registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            if (rst_por) begin
                status_q <= bsrd_pkg::RST_STATUS;
            end else begin
                status_q[bsrd_pkg::ST_TO] <= !rst_wdt;
                status_q[bsrd_pkg::ST_PD] <= !rst_sleep;
            end
        end else if (hit(bsrd_pkg::IDX_STATUS)) begin
            // Timeout and power-down are read only
            status_q[2:0] <= wdat[2:0] & bsrd_pkg::ST_WR_MASK[2:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_a_hi_q <= bsrd_pkg::RST_ZERO;
            ptr_b_hi_q <= bsrd_pkg::RST_ZERO;
            if (rst_por) begin
                ptr_a_lo_q <= bsrd_pkg::RST_ZERO;
                ptr_b_lo_q <= bsrd_pkg::RST_ZERO;
            end
        end else begin
            if (hit(bsrd_pkg::IDX_PTR_A_LO)) ptr_a_lo_q <= wdat;
            if (hit(bsrd_pkg::IDX_PTR_A_HI)) ptr_a_hi_q <= wdat;
            if (hit(bsrd_pkg::IDX_PTR_B_LO)) ptr_b_lo_q <= wdat;
            if (hit(bsrd_pkg::IDX_PTR_B_HI)) ptr_b_hi_q <= wdat;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bank_q <= bsrd_pkg::RST_ZERO[4:0];
            pc_latch_q <= bsrd_pkg::RST_ZERO[6:0];
            int_ctl_q <= bsrd_pkg::RST_ZERO;
            if (rst_por) begin
                wacc_q <= bsrd_pkg::RST_ZERO;
            end
        end else begin
            if (hit(bsrd_pkg::IDX_BANK_SEL)) bank_q <= wdat[4:0];
            if (hit(bsrd_pkg::IDX_WACC)) wacc_q <= wdat;
            if (hit(bsrd_pkg::IDX_PC_LATCH)) pc_latch_q <= wdat[6:0];
            if (hit(bsrd_pkg::IDX_INT_CTL)) int_ctl_q <= wdat;
        end
    end

    // Only the counter's low byte has an address; the latch feeds the upper bits on load
    bsrd_pc_unit u_pc (
        .clk_sys(clk_sys),
        .rst(rst),
        .low_wr(hit(bsrd_pkg::IDX_PC_LOW)),
        .low_val(wdat),
        .latch(pc_latch_q),
        .step(pc_step),
        .jump(pc_jump),
        .target(pc_target),
        .pc(pc)
    );

    // ****************************************
    // Capture/compare/PWM registers
    // ****************************************
    for (genvar i = 0; i < bsrd_pkg::CC_VALS; i++) begin : g_ccval
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                if (rst_por) begin
                    cc_val_q[i] <= bsrd_pkg::RST_ZERO;
                end
            end else if (hit(bsrd_pkg::CC_VAL_IDX[i])) begin
                cc_val_q[i] <= wdat;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cc3_ctl_q <= bsrd_pkg::RST_ZERO;
            cc3_db_q <= bsrd_pkg::RST_ZERO;
            cc3_as_q <= bsrd_pkg::RST_ZERO;
            cc3_str_q <= bsrd_pkg::RST_STEER;
            cc4_ctl_q <= bsrd_pkg::RST_ZERO[5:0];
            cc5_ctl_q <= bsrd_pkg::RST_ZERO[5:0];
        end else begin
            if (hit(bsrd_pkg::IDX_CC3_CTL)) cc3_ctl_q <= wdat;
            if (hit(bsrd_pkg::IDX_CC3_DB)) cc3_db_q <= wdat;
            if (hit(bsrd_pkg::IDX_CC3_AS)) cc3_as_q <= wdat;
            if (hit(bsrd_pkg::IDX_CC3_STR)) cc3_str_q <= wdat[4:0];
            if (hit(bsrd_pkg::IDX_CC4_CTL)) cc4_ctl_q <= wdat[5:0];
            if (hit(bsrd_pkg::IDX_CC5_CTL)) cc5_ctl_q <= wdat[5:0];
        end
    end

    // ****************************************
    // Register view for the rest of the core
    // ****************************************
    always_comb begin
        sfr.status = status_q;
        sfr.bank = bank_q;
        sfr.wacc = wacc_q;
        sfr.pc_latch = pc_latch_q;
        sfr.int_ctl = int_ctl_q;
        sfr.ptr_a = {ptr_a_hi_q, ptr_a_lo_q};
        sfr.ptr_b = {ptr_b_hi_q, ptr_b_lo_q};
        sfr.cc3_ctl = cc3_ctl_q;
        sfr.cc3_db = cc3_db_q;
        sfr.cc3_as = cc3_as_q;
        sfr.cc3_str = cc3_str_q;
        sfr.cc4_ctl = cc4_ctl_q;
        sfr.cc5_ctl = cc5_ctl_q;
    end

endmodule // bsrd_bank6

/* src/bsrd_pc_unit.sv */
`timescale 1ns/100ps
module bsrd_pc_unit (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic low_wr,
    input wire logic [7:0] low_val,
    input wire logic [6:0] latch,
    input wire logic step,
    input wire logic jump,
    input wire logic [10:0] target,
    output logic [14:0] pc
);
    logic [14:0] pc_q;
    logic [14:0] pc_d;

    // ****************************************
    // Counter load
    // ****************************************
    always_comb begin
        pc_d = pc_q;
        if (low_wr) begin
            pc_d = {latch, low_val};
        end else if (jump) begin
            pc_d = {latch[6:3], target};
        end else if (step) begin
            pc_d = pc_q + 15'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_q <= bsrd_pkg::RST_PC;
        end else begin
            pc_q <= pc_d;
        end
    end

    assign pc = pc_q;
endmodule // bsrd_pc_unit

/* src/bsrd_pkg.sv */
package bsrd_pkg;

    // ****************************************
    // Address map, index = byte address / 4
    // ****************************************
    localparam int unsigned IDX_W = 12;
    localparam logic [4:0] BANK_OWN = 5'h06;
    localparam logic [6:0] CORE_END = 7'h0c;
    localparam logic [11:0] IDX_IND_A = 12'h300;
    localparam logic [11:0] IDX_IND_B = 12'h301;
    localparam logic [11:0] IDX_PC_LOW = 12'h302;
    localparam logic [11:0] IDX_STATUS = 12'h303;
    localparam logic [11:0] IDX_PTR_A_LO = 12'h304;
    localparam logic [11:0] IDX_PTR_A_HI = 12'h305;
    localparam logic [11:0] IDX_PTR_B_LO = 12'h306;
    localparam logic [11:0] IDX_PTR_B_HI = 12'h307;
    localparam logic [11:0] IDX_BANK_SEL = 12'h308;
    localparam logic [11:0] IDX_WACC = 12'h309;
    localparam logic [11:0] IDX_PC_LATCH = 12'h30a;
    localparam logic [11:0] IDX_INT_CTL = 12'h30b;
    localparam logic [11:0] IDX_CC3_VLO = 12'h311;
    localparam logic [11:0] IDX_CC3_VHI = 12'h312;
    localparam logic [11:0] IDX_CC3_CTL = 12'h313;
    localparam logic [11:0] IDX_CC3_DB = 12'h314;
    localparam logic [11:0] IDX_CC3_AS = 12'h315;
    localparam logic [11:0] IDX_CC3_STR = 12'h316;
    localparam logic [11:0] IDX_CC4_VLO = 12'h318;
    localparam logic [11:0] IDX_CC4_VHI = 12'h319;
    localparam logic [11:0] IDX_CC4_CTL = 12'h31a;
    localparam logic [11:0] IDX_CC5_VLO = 12'h31c;
    localparam logic [11:0] IDX_CC5_VHI = 12'h31d;
    localparam logic [11:0] IDX_CC5_CTL = 12'h31e;
    localparam int unsigned CC_VALS = 6;
    localparam logic [11:0] CC_VAL_IDX [CC_VALS] = '{
        IDX_CC3_VLO, IDX_CC3_VHI, IDX_CC4_VLO, IDX_CC4_VHI, IDX_CC5_VLO, IDX_CC5_VHI};

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int unsigned ST_TO = 4;
    localparam int unsigned ST_PD = 3;
    localparam logic [7:0] ST_WR_MASK = 8'h07;
    localparam logic [7:0] RST_STATUS = 8'h18;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [4:0] RST_STEER = 5'h01;
    localparam logic [7:0] ONES_NONE = 8'h00;
    localparam logic [14:0] RST_PC = 15'h0000;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic stb;
        logic we;
        logic [15:0] adr;
        logic [7:0] wdat;
    } bsrd_mem_req_t;

    typedef struct packed {
        logic [7:0] status;
        logic [4:0] bank;
        logic [7:0] wacc;
        logic [6:0] pc_latch;
        logic [7:0] int_ctl;
        logic [15:0] ptr_a;
        logic [15:0] ptr_b;
        logic [7:0] cc3_ctl;
        logic [7:0] cc3_db;
        logic [7:0] cc3_as;
        logic [4:0] cc3_str;
        logic [5:0] cc4_ctl;
        logic [5:0] cc5_ctl;
    } bsrd_sfr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXT = 2'b01,
        ST_DONE = 2'b10
    } bsrd_state_t;

endpackage
